/* rtl/aasu_pkg.sv */
// Package for the accumulator add/saturate unit: widths, bit positions, limits, op codes.
// Assumes a single core instruction clock and one instruction per cycle.
package aasu_pkg;
   localparam int ACC_W = 40;
   // ===============================================
   // Register offsets (word index on the plain port)
   localparam logic [3:0] OFF_STATUS  = 4'h0;
   localparam logic [3:0] OFF_CONFIG  = 4'h1;
   localparam logic [3:0] OFF_TRAPCTL = 4'h2;
   localparam logic [3:0] OFF_WBPTR   = 4'h3;
   localparam logic [3:0] OFF_AL      = 4'h4;
   localparam logic [3:0] OFF_AH      = 4'h5;
   localparam logic [3:0] OFF_AU      = 4'h6;
   localparam logic [3:0] OFF_BL      = 4'h7;
   localparam logic [3:0] OFF_BH      = 4'h8;
   localparam logic [3:0] OFF_BU      = 4'h9;
   // ===============================================
   // Status word bits
   localparam int ST_OA  = 15;
   localparam int ST_OB  = 14;
   localparam int ST_SA  = 13;
   localparam int ST_SB  = 12;
   localparam int ST_OAB = 11;
   localparam int ST_SAB = 10;
   // Config word bits
   localparam int CF_RND    = 1;
   localparam int CF_ACCSW  = 4;
   localparam int CF_STSAT  = 5;
   localparam int CF_ACC_B_SAT_ENABLE   = 6;
   localparam int CF_ACC_A_SAT_ENABLE   = 7;
   localparam logic [15:0] CONFIG_RST = 16'h0020;
   // Trap control bits
   localparam int TC_COV = 8;
   localparam int TC_OVB = 9;
   localparam int TC_OVA = 10;
   // ===============================================
   // Limits
   localparam logic [39:0] MAX40 = 40'h7f_ffff_ffff;
   localparam logic [39:0] MIN40 = 40'h80_0000_0000;
   localparam logic [39:0] MAX32 = 40'h00_7fff_ffff;
   localparam logic [39:0] MIN32 = 40'hff_8000_0000;
   localparam logic [15:0] MAX16 = 16'h7fff;
   localparam logic [15:0] MIN16 = 16'h8000;
   localparam logic [15:0] HALF  = 16'h8000;
   localparam logic [15:0] WB_STEP = 16'h0002;
   // ===============================================
   typedef enum logic [2:0] {
      OP_NONE, OP_MAC, OP_MSC, OP_MPY, OP_MPYN, OP_ADD, OP_LAC, OP_SAC
   } aasu_op_t;
   typedef enum logic [1:0] {WB_NONE, WB_DIRECT, WB_INDIRECT} aasu_wb_t;
   typedef struct packed {
      aasu_op_t    op;
      logic        tgt_b;      // Target accumulator is B
      logic        prod_signed;
      logic [31:0] product;
      logic [15:0] xdata;      // Operand for add/load
      logic        use_shift;
      logic signed [5:0] shift; // Positive right, negative left
      logic        sac_round;
      aasu_wb_t    wb;
   } aasu_cmd_t;
endpackage

/* rtl/aasu_top.sv */
// Accumulator adder/subtractor with saturation, status flags, traps, store and write back.
// Assumes commands arrive one per clock from core decode; register port is synchronous.
// What this block does
// RULE1: 40-bit add/sub with A or B source/destination; signed product sign-extended.
// RULE2: Add and load operands optionally scaled by barrel shifter.
// RULE3: Operand negation for multiply-subtract and multiply-negate, operands untouched.
// RULE4: Read-only guard-overflow flags per accumulator, updated on each pass.
// RULE5: Combined overflow bit ORs guard flags; combined saturation ORs saturation flags.
// RULE6: Saturation flags sticky; clearing combined bit clears both.
// RULE7: Saturation flag set when result exceeds bit 31 or bit 39 range.
// RULE8: Guard overflow with its trap enable (bits 10, 9) raises trap.
// RULE9: Without saturation, saturation flag with catastrophic enable bit 8 raises trap.
// RULE10: 40-bit mode clamps to 0x7FFFFFFFFF or 0x8000000000 and flags.
// RULE11: Bit 4 selects 40/32-bit; bits 7 and 6 enable A and B saturation.
// RULE12: 32-bit mode clamps to 0x007FFFFFFF/0xFF80000000; with saturation on, guard flags never set.
// RULE13: Without saturation the accumulator wraps up to bit 39.
// RULE14: Mapped register writes leave accumulator status; general flags still update.
// RULE15: Store saturation enabled by bit 5, set at reset; source unchanged.
// RULE16: Store scales, then rounds for rounded variant, then saturates to 16 bits.
// RULE17: Store clamps above 0x007FFF to 0x7FFF, below 0xFF8000 to 0x8000.
// RULE18: Multiply-accumulate/subtract optionally write back rounded other accumulator.
// RULE19: Direct write back puts rounded 1.15 value into pointer register.
// RULE20: Indirect write back stores at pointer address, then pointer plus 2.
// RULE21: Each accumulator mapped as low, high and upper-byte words.
// RULE22: Rounding mode picks conventional or convergent (tie uses bit 16).
// RULE23: Flags and traps update in the same cycle as the result.
`timescale 1ns/100ps
`default_nettype none
module aasu_top
   import aasu_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire aasu_pkg::aasu_cmd_t cmd,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [15:0]              reg_rdata,
   output logic                     arith_trap,
   output logic                     xbus_wr,
   output logic [15:0]              xbus_addr,
   output logic [15:0]              xbus_wdata,
   output logic                     general_overflow_flag,
   output logic                     digit_carry_flag
);
   import aasu_pkg::*;

   // ===============================================
   // State
   logic [39:0] accumulator_a_q, accumulator_b_q;
   logic        acc_a_guard_overflow_q, acc_b_guard_overflow_q;
   logic        acc_a_saturated_q, acc_b_saturated_q;
   logic [15:0] core_config_word_q, trap_control_word_q, writeback_pointer_reg_q;
   logic [15:0] reg_rdata_q;
   logic        trap_q, xwr_q, ov_q, dc_q;
   logic [15:0] xaddr_q, xdata_q;

   // ===============================================
   // Barrel shifter (40 bits wide)
   function automatic logic [39:0] bshift(input logic [39:0] v, input logic signed [5:0] s);
      logic [5:0] m;
      m = s[5] ? 6'(-s) : 6'(s);
      bshift = s[5] ? (v << m) : 40'($signed(v) >>> m);
   endfunction

   // Round a 40-bit value to its 1.15 high word [RULE22]
   function automatic logic [39:0] rnd(input logic [39:0] v, input logic conv);
      logic up;
      up = conv ? ((v[15:0] > HALF) || (v[15:0] == HALF && v[16]))
                : (v[15:0] >= HALF);
      rnd = v + (up ? 40'h00_0001_0000 : 40'h00_0000_0000);
   endfunction

   // ===============================================
   // Datapath decode
   wire        is_mac   = (cmd.op == OP_MAC);
   wire        is_msc   = (cmd.op == OP_MSC);
   wire        is_mpy   = (cmd.op == OP_MPY) || (cmd.op == OP_MPYN);
   wire        is_add   = (cmd.op == OP_ADD);
   wire        is_lac   = (cmd.op == OP_LAC);
   wire        is_sac   = (cmd.op == OP_SAC);
   wire        acc_op   = is_mac | is_msc | is_mpy | is_add | is_lac;
   wire [39:0] src_acc  = cmd.tgt_b ? accumulator_b_q : accumulator_a_q;  // [RULE1]
   wire [39:0] oth_acc  = cmd.tgt_b ? accumulator_a_q : accumulator_b_q;
   wire [39:0] prod_ext = cmd.prod_signed ? {{8{cmd.product[31]}}, cmd.product}
                                          : {8'h00, cmd.product};        // [RULE1]
   wire [39:0] x_ext    = {{8{cmd.xdata[15]}}, cmd.xdata, 16'h0000};
   wire [39:0] x_sc     = cmd.use_shift ? bshift(x_ext, cmd.shift) : x_ext; // [RULE2]
   wire [39:0] opnd     = (is_add | is_lac) ? x_sc : prod_ext;
   wire        negate   = is_msc | (cmd.op == OP_MPYN);                   // [RULE3]
   wire [39:0] base     = (is_mpy | is_lac) ? 40'h00_0000_0000 : src_acc;
   wire [40:0] sum      = negate ? ({base[39], base} - {opnd[39], opnd})
                                 : ({base[39], base} + {opnd[39], opnd});
   wire        ovf39    = sum[40] ^ sum[39];
   wire        guard_ov = ~(&sum[39:31] | ~|sum[39:31]);
   wire        ovf31    = ovf39 | guard_ov;
   wire        sat_en   = cmd.tgt_b ? core_config_word_q[CF_ACC_B_SAT_ENABLE]
                                    : core_config_word_q[CF_ACC_A_SAT_ENABLE];       // [RULE11]
   wire        w40      = core_config_word_q[CF_ACCSW];
   wire        exceed   = w40 ? ovf39 : ovf31;                           // [RULE7]
   wire [39:0] clamp    = w40 ? (sum[40] ? MIN40 : MAX40)                 // [RULE10]
                              : (sum[40] ? MIN32 : MAX32);                // [RULE12]
   // Without saturation the sum simply wraps into bit 39 [RULE13]
   wire [39:0] result   = (sat_en && exceed) ? clamp : sum[39:0];
   // In 32-bit mode with saturation, guard bits only sign-extend [RULE12]
   wire        gov_new  = (sat_en && !w40) ? 1'b0 : (result[39:31] != {9{result[39]}}) | ovf39;
   wire        sat_new  = exceed;
   wire        conv     = core_config_word_q[CF_RND];

   // Store path: scale, optionally round, then 16-bit clamp [RULE16]
   wire [39:0] st_sc    = bshift(src_acc, cmd.shift);
   wire [39:0] st_rn    = cmd.sac_round ? rnd(st_sc, conv) : st_sc;
   wire        st_hi    = !st_rn[39] && (st_rn[39:31] != 9'h000);
   wire        st_lo    = st_rn[39] && (st_rn[39:31] != 9'h1ff);
   wire [15:0] st_val   = !core_config_word_q[CF_STSAT] ? st_rn[31:16] :
                          st_hi ? MAX16 : st_lo ? MIN16 : st_rn[31:16];  // [RULE17]

   // Write back of the non-target accumulator, always rounded [RULE18]
   wire        wb_go    = (is_mac | is_msc) && (cmd.wb != WB_NONE);
   wire [39:0] wb_rn    = rnd(oth_acc, conv);
   wire [15:0] wb_val   = wb_rn[31:16];

   // ===============================================
   // Register port decode [RULE21]
   wire        wr_cfg  = reg_wr && reg_addr == OFF_CONFIG;
   wire        wr_trp  = reg_wr && reg_addr == OFF_TRAPCTL;
   wire        wr_ptr  = reg_wr && reg_addr == OFF_WBPTR;
   wire        wr_st   = reg_wr && reg_addr == OFF_STATUS;
   wire        wr_a    = reg_wr && (reg_addr == OFF_AL || reg_addr == OFF_AH ||
                                    reg_addr == OFF_AU);
   wire        wr_b    = reg_wr && (reg_addr == OFF_BL || reg_addr == OFF_BH ||
                                    reg_addr == OFF_BU);
   // Clearing the combined bit clears both saturation flags [RULE6]
   wire        clr_sat = wr_st && !reg_wdata[ST_SAB];

   function automatic logic [39:0] mapw(input logic [39:0] a, input logic [3:0] ad,
                                        input logic [15:0] d, input logic [3:0] lo);
      mapw = a;
      if (ad == lo) mapw[15:0] = d;
      else if (ad == lo + 4'h1) mapw[31:16] = d;
      else mapw[39:32] = d[7:0];
   endfunction

   wire        upd_a = acc_op && !cmd.tgt_b;
   wire        upd_b = acc_op && cmd.tgt_b;
   wire [39:0] a_d   = upd_a ? result
                     : wr_a ? mapw(accumulator_a_q, reg_addr, reg_wdata, OFF_AL)
                     : accumulator_a_q;                                  // [RULE15]
   wire [39:0] b_d   = upd_b ? result
                     : wr_b ? mapw(accumulator_b_q, reg_addr, reg_wdata, OFF_BL)
                     : accumulator_b_q;
   // Guard flags follow each pass; mapped writes leave them [RULE4] [RULE14]
   wire        oa_d  = upd_a ? gov_new : acc_a_guard_overflow_q;
   wire        ob_d  = upd_b ? gov_new : acc_b_guard_overflow_q;
   // Hardware set wins over software clear [RULE6]
   wire        sa_d  = (upd_a & sat_new) | (acc_a_saturated_q & ~clr_sat);
   wire        sb_d  = (upd_b & sat_new) | (acc_b_saturated_q & ~clr_sat);
   // Traps in the same cycle as the result [RULE23]
   wire        trap_d = (upd_a & gov_new & trap_control_word_q[TC_OVA])      // [RULE8]
                      | (upd_b & gov_new & trap_control_word_q[TC_OVB])
                      | (acc_op & sat_new & ~sat_en & trap_control_word_q[TC_COV]); // [RULE9]
   // Mapped writes update the general flags from the written word [RULE14]
   wire        ovf_d  = (wr_a | wr_b) ? reg_wdata[15] : ov_q;
   wire        dcf_d  = (wr_a | wr_b) ? reg_wdata[4] : dc_q;
   wire [15:0] ptr_d  = (wb_go && cmd.wb == WB_DIRECT) ? wb_val               // [RULE19]
                      : (wb_go && cmd.wb == WB_INDIRECT) ? writeback_pointer_reg_q + WB_STEP
                      : wr_ptr ? reg_wdata : writeback_pointer_reg_q;     // [RULE20]
   wire        xwr_d  = is_sac | (wb_go && cmd.wb == WB_INDIRECT);
   wire [15:0] xad_d  = writeback_pointer_reg_q;
   wire [15:0] xdt_d  = is_sac ? st_val : wb_val;

   wire [15:0] status_w = {acc_a_guard_overflow_q, acc_b_guard_overflow_q,
                           acc_a_saturated_q, acc_b_saturated_q,
                           acc_a_guard_overflow_q | acc_b_guard_overflow_q,   // [RULE5]
                           acc_a_saturated_q | acc_b_saturated_q, 10'h000};
   logic [15:0] rd_mux;
   always_comb begin
      unique case (reg_addr)
         OFF_STATUS:  rd_mux = status_w;
         OFF_CONFIG:  rd_mux = core_config_word_q;
         OFF_TRAPCTL: rd_mux = trap_control_word_q;
         OFF_WBPTR:   rd_mux = writeback_pointer_reg_q;
         OFF_AL:      rd_mux = accumulator_a_q[15:0];
         OFF_AH:      rd_mux = accumulator_a_q[31:16];
         OFF_AU:      rd_mux = {{8{accumulator_a_q[39]}}, accumulator_a_q[39:32]};
         OFF_BL:      rd_mux = accumulator_b_q[15:0];
         OFF_BH:      rd_mux = accumulator_b_q[31:16];
         OFF_BU:      rd_mux = {{8{accumulator_b_q[39]}}, accumulator_b_q[39:32]};
         default:     rd_mux = 16'h0000;
      endcase
   end

   // ===============================================
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator_a_q         <= 40'h00_0000_0000;
         accumulator_b_q         <= 40'h00_0000_0000;
         acc_a_guard_overflow_q  <= 1'b0;
         acc_b_guard_overflow_q  <= 1'b0;
         acc_a_saturated_q       <= 1'b0;
         acc_b_saturated_q       <= 1'b0;
         core_config_word_q      <= CONFIG_RST;                            // [RULE15]
         trap_control_word_q     <= 16'h0000;
         writeback_pointer_reg_q <= 16'h0000;
         reg_rdata_q             <= 16'h0000;
         trap_q                  <= 1'b0;
         xwr_q                   <= 1'b0;
         xaddr_q                 <= 16'h0000;
         xdata_q                 <= 16'h0000;
         ov_q                    <= 1'b0;
         dc_q                    <= 1'b0;
      end else begin
         accumulator_a_q         <= a_d;
         accumulator_b_q         <= b_d;
         acc_a_guard_overflow_q  <= oa_d;
         acc_b_guard_overflow_q  <= ob_d;
         acc_a_saturated_q       <= sa_d;
         acc_b_saturated_q       <= sb_d;
         if (wr_cfg) core_config_word_q <= reg_wdata;
         if (wr_trp) trap_control_word_q <= reg_wdata;
         writeback_pointer_reg_q <= ptr_d;
         reg_rdata_q             <= reg_rd ? rd_mux : 16'h0000;
         trap_q                  <= trap_d;
         xwr_q                   <= xwr_d;
         xaddr_q                 <= xad_d;
         xdata_q                 <= xdt_d;
         ov_q                    <= ovf_d;
         dc_q                    <= dcf_d;
      end
   end

   assign reg_rdata             = reg_rdata_q;
   assign arith_trap            = trap_q;
   assign xbus_wr               = xwr_q;
   assign xbus_addr             = xaddr_q;
   assign xbus_wdata            = xdata_q;
   assign general_overflow_flag = ov_q;
   assign digit_carry_flag      = dc_q;

   // ===============================================
   // Checks
   AST_SAT_A_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
      acc_a_saturated_q && !clr_sat |=> acc_a_saturated_q)
      else $error("sat A flag dropped"); // [RULE6]
   AST_SAB_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      clr_sat && !(acc_op && sat_new) |=> !acc_a_saturated_q && !acc_b_saturated_q)
      else $error("combined clear failed"); // [RULE6]
   AST_SAT40_MAX: assert property (@(posedge clk) disable iff (!rst_n)
      upd_a && sat_en && w40 && ovf39 && !sum[40] |=> accumulator_a_q == MAX40)
      else $error("40-bit clamp wrong"); // [RULE10]
   AST_SAT32_MIN: assert property (@(posedge clk) disable iff (!rst_n)
      upd_b && sat_en && !w40 && ovf31 && sum[40] |=> accumulator_b_q == MIN32)
      else $error("32-bit clamp wrong"); // [RULE12]
   AST_GUARD32: assert property (@(posedge clk) disable iff (!rst_n)
      upd_a && sat_en && !w40 |=> !acc_a_guard_overflow_q)
      else $error("guard flag in 32-bit mode"); // [RULE12]
   AST_TRAP_OVA: assert property (@(posedge clk) disable iff (!rst_n)
      upd_a && gov_new && trap_control_word_q[TC_OVA] |=> arith_trap)
      else $error("missing overflow trap"); // [RULE8]
   AST_MAP_KEEPS: assert property (@(posedge clk) disable iff (!rst_n)
      wr_a && !acc_op |=> $stable(acc_a_guard_overflow_q))
      else $error("mapped write moved status"); // [RULE14]
   AST_PTR_STEP: assert property (@(posedge clk) disable iff (!rst_n)
      wb_go && cmd.wb == WB_INDIRECT |=>
      writeback_pointer_reg_q == $past(writeback_pointer_reg_q) + WB_STEP)
      else $error("pointer step wrong"); // [RULE20]
   AST_STORE_MAX: assert property (@(posedge clk) disable iff (!rst_n)
      is_sac && core_config_word_q[CF_STSAT] && st_hi |=> xbus_wr && xbus_wdata == MAX16)
      else $error("store clamp wrong"); // [RULE17]
endmodule
`default_nettype wire

/* verif/aasu_xbus_model.sv */
// Partner model of the X data bus: records the writes that the unit issues into data space.
// Assumes at most one registered write a cycle and the unit's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module aasu_xbus_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wdata,
   output logic [15:0]      last_addr,
   output logic [15:0]      last_data,
   output logic [7:0]       wr_count
);
   // ===============================================
   // Capture
   // Only the latest write is kept; the count shows stray or missing writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_addr <= 16'h0000;
         last_data <= 16'h0000;
         wr_count  <= 8'h00;
      end else if (wr) begin
         last_addr <= addr;
         last_data <= wdata;
         wr_count  <= wr_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the accumulator add/saturate unit: instruction table, then
// reset, trap, sticky-flag and write-back cases. Assumes the register port timing of the unit.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import aasu_pkg::*;
   // ===============================================
   // Signals
   typedef struct packed {
      aasu_op_t          op;
      logic [2:0]        fl;
      logic [7:0]        cfg;
      logic [39:0]       acc;
      logic [31:0]       prod;
      logic [15:0]       xd;
      logic signed [5:0] sh;
      logic [39:0]       exp;
      logic [5:0]        st;
   } aasu_row_t;
   logic        clk       = 1'b0;
   logic        rst_n     = 1'b0;
   aasu_cmd_t   cmd       = '0;
   logic [3:0]  reg_addr  = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [15:0] reg_rdata, xbus_addr, xbus_wdata, last_addr, last_data, rd;
   logic        arith_trap, xbus_wr, gov_flag, dc_flag;
   logic [7:0]  wr_count;
   int          fails = 0, num_checks = 0, cycles = 0, n_wr = 1;
   // Flags column: target B, signed product, rounded store
   // Guard flags of the untouched accumulator carry over from earlier rows
   aasu_row_t rows [0:19] = '{
      '{OP_MAC, 3'h2, 8'hb0, 40'h7f_ffff_ffff, 32'h1, 16'h0, 6'h0, 40'h7f_ffff_ffff, 6'h2b},
      '{OP_MAC, 3'h6, 8'h70, 40'h7f_ffff_ffff, 32'h1, 16'h0, 6'h0, 40'h7f_ffff_ffff, 6'h37},
      '{OP_MAC, 3'h2, 8'h70, 40'h7f_ffff_ffff, 32'h1, 16'h0, 6'h0, 40'h80_0000_0000, 6'h3b},
      '{OP_MAC, 3'h2, 8'ha0, 40'h00_7fff_ffff, 32'h1, 16'h0, 6'h0, 40'h00_7fff_ffff, 6'h1b},
      '{OP_MSC, 3'h2, 8'ha0, 40'hff_8000_0000, 32'h1, 16'h0, 6'h0, 40'hff_8000_0000, 6'h1b},
      '{OP_MAC, 3'h2, 8'h30, 40'h00_7fff_ffff, 32'h1, 16'h0, 6'h0, 40'h00_8000_0000, 6'h32},
      '{OP_MSC, 3'h6, 8'h20, 40'h0, 32'h5, 16'h0, 6'h0, 40'hff_ffff_fffb, 6'h22},
      '{OP_MPYN, 3'h2, 8'h20, 40'h12, 32'h3, 16'h0, 6'h0, 40'hff_ffff_fffd, 6'h00},
      '{OP_MPY, 3'h0, 8'h30, 40'h0, 32'h8000_0000, 16'h0, 6'h0, 40'h00_8000_0000, 6'h22},
      '{OP_ADD, 3'h2, 8'h20, 40'h00_0001_0000, 32'h0, 16'h2, 6'h0, 40'h00_0003_0000, 6'h00},
      '{OP_LAC, 3'h6, 8'h20, 40'h0, 32'h0, 16'h8000, 6'h0, 40'hff_8000_0000, 6'h00},
      '{OP_LAC, 3'h2, 8'h20, 40'h0, 32'h0, 16'h4000, 6'h1, 40'h00_2000_0000, 6'h00},
      '{OP_SAC, 3'h2, 8'h20, 40'h01_0000_0000, 32'h0, 16'h0, 6'h0, 40'h7fff, 6'h00},
      '{OP_SAC, 3'h2, 8'h20, 40'hfe_0000_0000, 32'h0, 16'h0, 6'h0, 40'h8000, 6'h00},
      '{OP_SAC, 3'h2, 8'h20, 40'h00_1234_5678, 32'h0, 16'h0, 6'h0, 40'h1234, 6'h00},
      '{OP_SAC, 3'h2, 8'h20, 40'h00_1234_5678, 32'h0, 16'h0, 6'h3f, 40'h2468, 6'h00},
      '{OP_SAC, 3'h3, 8'h20, 40'h00_1234_8000, 32'h0, 16'h0, 6'h0, 40'h1235, 6'h00},
      '{OP_SAC, 3'h3, 8'h22, 40'h00_1234_8000, 32'h0, 16'h0, 6'h0, 40'h1234, 6'h00},
      '{OP_SAC, 3'h3, 8'h20, 40'h00_7fff_8000, 32'h0, 16'h0, 6'h0, 40'h7fff, 6'h00},
      '{OP_SAC, 3'h2, 8'h00, 40'h01_0000_0000, 32'h0, 16'h0, 6'h0, 40'h0000, 6'h00}};
   // ===============================================
   // Instances and clock
   aasu_top i_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .arith_trap(arith_trap), .xbus_wr(xbus_wr), .xbus_addr(xbus_addr),
      .xbus_wdata(xbus_wdata), .general_overflow_flag(gov_flag), .digit_carry_flag(dc_flag));
   aasu_xbus_model i_xbus (.clk(clk), .rst_n(rst_n), .wr(xbus_wr), .addr(xbus_addr),
      .wdata(xbus_wdata), .last_addr(last_addr), .last_data(last_data), .wr_count(wr_count));
   always #50 clk = ~clk;
   // Whole run is well under 2000 cycles; a hang ends here
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         conclude();
      end
   end
   // ===============================================
   // Tasks
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      num_checks++;
      if (seen !== want) begin
         fails++;
         $display("BAD %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task automatic acc_write(input logic [3:0] b, input logic [39:0] v);
      reg_write(b, v[15:0]);
      reg_write(b + 4'h1, v[31:16]);
      reg_write(b + 4'h2, {8'h00, v[39:32]});
   endtask
   task automatic acc_check(input logic [3:0] b, input logic [39:0] v);
      reg_read(b);
      check(rd, v[15:0]);
      reg_read(b + 4'h1);
      check(rd, v[31:16]);
      reg_read(b + 4'h2);
      check(rd, {{8{v[39]}}, v[39:32]});
   endtask
   // Command is held one cycle; outputs are sampled just after the edge that takes it
   task automatic issue(input aasu_cmd_t c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= '0;
      #1;
   endtask
   function automatic aasu_cmd_t mk(input aasu_op_t op, input logic [2:0] fl,
                                    input logic [31:0] p);
      aasu_cmd_t c;
      c             = '0;
      c.op          = op;
      c.tgt_b       = fl[2];
      c.prod_signed = fl[1];
      c.sac_round   = fl[0];
      c.product     = p;
      return c;
   endfunction
   task automatic run_row(input aasu_row_t r);
      aasu_cmd_t  c;
      logic [3:0] b;
      b = r.fl[2] ? OFF_BL : OFF_AL;
      reg_write(OFF_CONFIG, {8'h00, r.cfg});
      reg_write(OFF_STATUS, 16'h0000);
      acc_write(b, r.acc);
      c           = mk(r.op, r.fl, r.prod);
      c.xdata     = r.xd;
      c.shift     = r.sh;
      c.use_shift = (r.sh != 6'sd0);
      issue(c);
      check(arith_trap, 1'b0);
      check(xbus_wr, r.op == OP_SAC);
      if (r.op == OP_SAC) begin
         check(xbus_wdata, r.exp[15:0]);
         acc_check(b, r.acc);
      end else begin
         acc_check(b, r.exp);
      end
      reg_read(OFF_STATUS);
      check(rd[15:10], r.st);
   endtask
   // ===============================================
   // Sequence
   initial begin
      aasu_cmd_t c;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      reg_read(OFF_CONFIG);
      check(rd, 16'h0020);
      reg_read(OFF_STATUS);
      check(rd, 16'h0000);
      reg_write(4'hf, 16'hffff);
      reg_read(4'hf);
      check(rd, 16'h0000);
      foreach (rows[i]) begin
         run_row(rows[i]);
         if (rows[i].op == OP_SAC) n_wr++;
      end
      // Guard overflow trap, then catastrophic trap, with a one-cycle pulse
      reg_write(OFF_CONFIG, 16'h0030);
      reg_write(OFF_TRAPCTL, 16'h0400);
      acc_write(OFF_AL, 40'h00_7fff_ffff);
      issue(mk(OP_MAC, 3'h2, 32'h1));
      check(arith_trap, 1'b1);
      @(posedge clk);
      #1 check(arith_trap, 1'b0);
      reg_write(OFF_TRAPCTL, 16'h0100);
      acc_write(OFF_AL, 40'h7f_ffff_ffff);
      issue(mk(OP_MAC, 3'h2, 32'h1));
      check(arith_trap, 1'b1);
      issue(mk(OP_MAC, 3'h2, 32'h0));
      reg_write(OFF_AH, 16'h8010);
      #1 check({gov_flag, dc_flag}, 2'h3);
      reg_read(OFF_STATUS);
      check({rd[13], rd[10]}, 2'h3);
      reg_write(OFF_STATUS, 16'h0000);
      reg_read(OFF_STATUS);
      check({rd[13:12], rd[10]}, 3'h0);
      // Write back of the rounded other accumulator
      reg_write(OFF_TRAPCTL, 16'h0000);
      reg_write(OFF_WBPTR, 16'h0100);
      acc_write(OFF_BL, 40'h00_4000_8000);
      c    = mk(OP_MSC, 3'h2, 32'h0);
      c.wb = WB_INDIRECT;
      issue(c);
      check({xbus_wr, xbus_addr, xbus_wdata}, {1'b1, 16'h0100, 16'h4001});
      reg_read(OFF_WBPTR);
      check(rd, 16'h0102);
      c.op = OP_MAC;
      c.wb = WB_DIRECT;
      issue(c);
      check(xbus_wr, 1'b0);
      reg_read(OFF_WBPTR);
      check(rd, 16'h4001);
      check({wr_count, last_addr, last_data}, {8'(n_wr), 16'h0100, 16'h4001});
      // Reset in mid-run restores the store saturation default
      reg_write(OFF_CONFIG, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      reg_read(OFF_CONFIG);
      check(rd, 16'h0020);
      conclude();
   end
endmodule
`default_nettype wire
